//--- drive_loop_pkg.sv
// Constants shared by the drive loop and fault signalling block.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone register bus.
package drive_loop_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned BASE_PERIOD_NS = 100000;
  localparam int unsigned BASE_PERIOD_CYC = BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned LIMIT_SETTLE_NS = 5000000;
  localparam logic [15:0] CI_GAIN_RST = 16'((256 * 4 * BASE_PERIOD_NS) / LIMIT_SETTLE_NS);
  localparam logic [7:0] PDO_ASYNC_TYPE = 8'hff;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TARGET = 8'h04;
  localparam logic [7:0] ADR_WIN = 8'h08;
  localparam logic [7:0] ADR_WIN_TIME = 8'h0c;
  localparam logic [7:0] ADR_PGAIN = 8'h10;
  localparam logic [7:0] ADR_VGAIN = 8'h14;
  localparam logic [7:0] ADR_VDIV = 8'h18;
  localparam logic [7:0] ADR_ACCDEC = 8'h1c;
  localparam logic [7:0] ADR_PROF_VEL = 8'h20;
  localparam logic [7:0] ADR_CUR_LIM = 8'h24;
  localparam logic [7:0] ADR_CI_THERM = 8'h28;
  localparam logic [7:0] ADR_ERR_DELAY = 8'h2c;
  localparam logic [7:0] ADR_MAX_DEV = 8'h30;
  localparam logic [7:0] ADR_ERR_CFG = 8'h34;
  localparam logic [7:0] ADR_STATUS = 8'h38;
  localparam logic [7:0] ADR_POS_ACT = 8'h3c;
  localparam logic [7:0] ADR_CMD = 8'h40;

  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_FN_LO = 1;
  localparam int CTRL_GEN_OUT = 3;
  localparam int CTRL_POL_POS = 4;
  localparam int CTRL_POL_NEG = 5;
  localparam int CTRL_LIM_POL_HOME = 6;
  localparam int CTRL_HOME_EN = 7;
  localparam int CTRL_HOME_POL = 8;
  localparam int CTRL_HOME_SRC_LO = 9;
  localparam int CFG_PIN_LO = 0;
  localparam int CFG_EMCY_LO = 8;
  localparam int CFG_SEL_LO = 16;
  localparam int CFG_PDO_LO = 24;
  localparam int STS_FAULT = 5;
  localparam int STS_HOME = 6;

  localparam logic [1:0] FN_ERROR = 2'h0;
  localparam logic [1:0] FN_TARGET = 2'h1;
  localparam logic [1:0] FN_GENERAL = 2'h2;
  localparam logic [1:0] FN_REF_IN = 2'h3;
  localparam logic [1:0] HSRC_SWITCH = 2'h0;
  localparam logic [1:0] HSRC_FAULT_PIN = 2'h1;
  localparam logic [1:0] HSRC_LIM_POS = 2'h2;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WIN_RST = 32'h0000_0010;
  localparam logic [31:0] WIN_TIME_RST = 32'h0000_0010;
  localparam logic [31:0] PGAIN_RST = 32'h0000_0100;
  localparam logic [31:0] VGAIN_RST = 32'h0010_0100;
  localparam logic [7:0] VDIV_RST = 8'h01;
  localparam logic [31:0] ACCDEC_RST = 32'h0010_0010;
  localparam logic [31:0] PROF_VEL_RST = 32'h0000_1000;
  localparam logic [31:0] CUR_LIM_RST = 32'h0400_0800;
  localparam logic [15:0] THERM_RST = 16'h1000;
  localparam logic [31:0] ERR_DELAY_RST = 32'h0000_0100;
  localparam logic [31:0] MAX_DEV_RST = 32'h0000_1000;
  localparam logic [31:0] ERR_CFG_RST = 32'hff00_0707;

  typedef enum logic [1:0] {ST_DISABLED, ST_ENABLED, ST_FAULT} drive_state_t;
endpackage : drive_loop_pkg

//--- drive_loop_and_fault_signalling.sv
// Cascaded position, velocity and current-limit loops with fault supervision.
// Assumes synchronous feedback inputs and a Wishbone master on the same clock.
// Notes on behaviour
// - Target reached only after dwell inside window.
// - Type 255 sends status on reached change.
// - In corridor: derivative on, ramp bypassed.
// - Velocity demand is position error times gain.
// - Velocity PI with settable gains and sampling.
// - Ramp limits accel, decel, clamps profile velocity.
// - Current limit peak, lowered to continuous thermally.
// - Current loop only limits, settles by gain.
// - Flag when limit lowered to continuous.
// - Faults reported after persisting error delay.
// - Velocity deviation error routed by mask bits.
// - Selected errors force drive fault state.
// - Fault pin has four selectable functions.
// - Target mode: pin low when reached.
// - General mode: pin follows software bit.
// - Reference mode: pin samples homing switch.
// - Limit switch edge blocks its direction.
// - Homing switch zeroes the actual position.
// - Optional limit polarity overrides homing polarity.
`timescale 1ns/1ns
module drive_loop_and_fault_signalling
  import drive_loop_pkg::*;
#(
  parameter int unsigned BASE_CYC = BASE_PERIOD_CYC
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Feedback
  input wire logic [31:0] enc_pos_i,
  input wire logic [31:0] vel_act_i,
  input wire logic [15:0] cur_act_i,
  input wire logic overcurrent_i,
  input wire logic overvoltage_i,
  // Switches
  input wire logic limit_pos_i,
  input wire logic limit_neg_i,
  input wire logic home_sw_i,
  // Fault pin
  input wire logic fault_pin_i,
  output logic fault_pin_o,
  output logic fault_pin_oe_o,
  // Drive and status outputs
  output logic [31:0] current_cmd_o,
  output logic pos_zero_o,
  output logic emcy_req_o,
  output logic [2:0] emcy_code_o,
  output logic pdo_req_o,
  output logic fault_state_o,
  output logic target_reached_o,
  output logic current_limiting_o
);
  if (BASE_CYC < 2) $error("BASE_CYC must be at least 2");

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] mag(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction : mag

  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] ctrl_ff, win_ff, win_time_ff, pgain_ff, vgain_ff, accdec_ff, prof_ff;
  logic [31:0] cur_lim_ff, err_delay_ff, max_dev_ff, err_cfg_ff;
  logic [15:0] ci_ff, therm_ff;
  logic [7:0] vdiv_ff, vcnt_ff;
  logic signed [31:0] target_ff, offset_ff, perr_prev_ff, vset_ff, integ_ff, lim_ff, cmd_ff;
  logic [31:0] i2t_ff, tick_cnt_ff, dwell_ff;
  logic new_tgt_ff, reached_ff, limiting_ff, pdo_ff, emcy_ff, pin_o_ff, pin_oe_ff, zero_ff, home_done_ff, fault_ff;
  logic [2:0] emcy_code_ff, err_ff;
  logic [31:0] err_cnt_ff [3];
  logic [1:0] lim_prev_ff, blk_ff;
  logic src_prev_ff;
  drive_state_t state_ff;

  logic wr, rd, tick, sample, in_win, accel, home_src, home_pol, home_hit;
  logic [2:0] err_cond;
  logic [1:0] fn;
  logic [31:0] i2t_n, sq, csq, status;
  logic signed [31:0] pos_act, perr, vdem, vstep, vdiff, ramp_v, prof_s, verr, u, lim_tgt, ldiff, lstep, cmd_c;
  logic signed [47:0] p_prod, d_prod, kp_prod, ki_prod, l_prod;

  // A write commits on the edge at which the master samples ack, never before the answer.
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_ff;
  assign tick = tick_cnt_ff == 32'(BASE_CYC - 1);
  assign sample = tick && ({24'h0, vcnt_ff} + 32'h1 >= {24'h0, vdiv_ff});
  assign fn = ctrl_ff[CTRL_FN_LO +: 2];
  assign status = {23'h0, blk_ff, home_done_ff, state_ff == ST_FAULT, err_ff, limiting_ff, reached_ff};

  always_comb
  begin
    pos_act = $signed(enc_pos_i) - offset_ff;
    perr = target_ff - pos_act;
    in_win = mag(perr) <= win_ff;
    p_prod = perr * $signed({1'b0, pgain_ff[15:0]});
    d_prod = (perr - perr_prev_ff) * $signed({1'b0, pgain_ff[31:16]});
    vdem = p_prod[39:8] + (in_win ? d_prod[39:8] : 32'sh0);
    accel = (vdem[31] == vset_ff[31] || vset_ff == 32'sh0) && mag(vdem) > mag(vset_ff);
    vstep = accel ? $signed({16'h0, accdec_ff[15:0]}) : $signed({16'h0, accdec_ff[31:16]});
    vdiff = vdem - vset_ff;
    prof_s = $signed({1'b0, prof_ff[30:0]});
    if (in_win) ramp_v = vdem;
    else
    begin
      if (vdiff > vstep) ramp_v = vset_ff + vstep;
      else if (vdiff < -vstep) ramp_v = vset_ff - vstep;
      else ramp_v = vdem;
      if (ramp_v > prof_s) ramp_v = prof_s;
      else if (ramp_v < -prof_s) ramp_v = -prof_s;
    end
    verr = vset_ff - $signed(vel_act_i);
    kp_prod = verr * $signed({1'b0, vgain_ff[15:0]});
    ki_prod = verr * $signed({1'b0, vgain_ff[31:16]});
    u = kp_prod[39:8] + integ_ff;
    lim_tgt = limiting_ff ? $signed({16'h0, cur_lim_ff[31:16]}) : $signed({16'h0, cur_lim_ff[15:0]});
    ldiff = lim_tgt - lim_ff;
    l_prod = ldiff * $signed({1'b0, ci_ff});
    lstep = l_prod[39:8];
    if (lstep == 32'sh0 && ldiff != 32'sh0) lstep = ldiff[31] ? -32'sh1 : 32'sh1;
    cmd_c = u;
    if (cmd_c > lim_ff) cmd_c = lim_ff;
    else if (cmd_c < -lim_ff) cmd_c = -lim_ff;
    if (blk_ff[0] && cmd_c > 32'sh0) cmd_c = 32'sh0;
    if (blk_ff[1] && cmd_c < 32'sh0) cmd_c = 32'sh0;
    sq = {16'h0, cur_act_i} * {16'h0, cur_act_i};
    csq = {16'h0, cur_lim_ff[31:16]} * {16'h0, cur_lim_ff[31:16]};
    if (sq >= csq) i2t_n = (i2t_ff > ~((sq - csq) >> 10)) ? 32'hffff_ffff : i2t_ff + ((sq - csq) >> 10);
    else i2t_n = (i2t_ff > ((csq - sq) >> 10)) ? i2t_ff - ((csq - sq) >> 10) : 32'h0;
    err_cond = {mag(vset_ff - $signed(vel_act_i)) > max_dev_ff, overvoltage_i, overcurrent_i};
    case (ctrl_ff[CTRL_HOME_SRC_LO +: 2])
      HSRC_SWITCH: home_src = home_sw_i;
      HSRC_FAULT_PIN: home_src = (fn == FN_REF_IN) & fault_pin_i;
      HSRC_LIM_POS: home_src = limit_pos_i;
      default: home_src = limit_neg_i;
    endcase
    home_pol = ctrl_ff[CTRL_HOME_POL];
    if (ctrl_ff[CTRL_HOME_SRC_LO + 1] && ctrl_ff[CTRL_LIM_POL_HOME])
      home_pol = ctrl_ff[CTRL_HOME_SRC_LO] ? ctrl_ff[CTRL_POL_NEG] : ctrl_ff[CTRL_POL_POS];
    home_hit = home_pol ? (home_src & ~src_prev_ff) : (~home_src & src_prev_ff);
  end

  // Registered ack; each access is answered exactly one cycle after it is seen.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
      if (rd)
      begin
        if (wb_adr_i == ADR_CTRL) rdat_ff <= ctrl_ff;
        else if (wb_adr_i == ADR_TARGET) rdat_ff <= target_ff;
        else if (wb_adr_i == ADR_WIN) rdat_ff <= win_ff;
        else if (wb_adr_i == ADR_WIN_TIME) rdat_ff <= win_time_ff;
        else if (wb_adr_i == ADR_PGAIN) rdat_ff <= pgain_ff;
        else if (wb_adr_i == ADR_VGAIN) rdat_ff <= vgain_ff;
        else if (wb_adr_i == ADR_VDIV) rdat_ff <= {24'h0, vdiv_ff};
        else if (wb_adr_i == ADR_ACCDEC) rdat_ff <= accdec_ff;
        else if (wb_adr_i == ADR_PROF_VEL) rdat_ff <= prof_ff;
        else if (wb_adr_i == ADR_CUR_LIM) rdat_ff <= cur_lim_ff;
        else if (wb_adr_i == ADR_CI_THERM) rdat_ff <= {therm_ff, ci_ff};
        else if (wb_adr_i == ADR_ERR_DELAY) rdat_ff <= err_delay_ff;
        else if (wb_adr_i == ADR_MAX_DEV) rdat_ff <= max_dev_ff;
        else if (wb_adr_i == ADR_ERR_CFG) rdat_ff <= err_cfg_ff;
        else if (wb_adr_i == ADR_STATUS) rdat_ff <= status;
        else if (wb_adr_i == ADR_POS_ACT) rdat_ff <= pos_act;
        else if (wb_adr_i == ADR_CMD) rdat_ff <= cmd_ff;
        else rdat_ff <= 32'h0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff <= CTRL_RST;
      target_ff <= 32'sh0;
      win_ff <= WIN_RST;
      win_time_ff <= WIN_TIME_RST;
      pgain_ff <= PGAIN_RST;
      vgain_ff <= VGAIN_RST;
      vdiv_ff <= VDIV_RST;
      accdec_ff <= ACCDEC_RST;
      prof_ff <= PROF_VEL_RST;
      cur_lim_ff <= CUR_LIM_RST;
      ci_ff <= CI_GAIN_RST;
      therm_ff <= THERM_RST;
      err_delay_ff <= ERR_DELAY_RST;
      max_dev_ff <= MAX_DEV_RST;
      err_cfg_ff <= ERR_CFG_RST;
      new_tgt_ff <= 1'b0;
    end
    else
    begin
      new_tgt_ff <= wr && wb_adr_i == ADR_TARGET;
      if (wr)
      begin
        if (wb_adr_i == ADR_CTRL) ctrl_ff <= merge(ctrl_ff, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_TARGET) target_ff <= merge(target_ff, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_WIN) win_ff <= merge(win_ff, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_WIN_TIME) win_time_ff <= merge(win_time_ff, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_PGAIN) pgain_ff <= merge(pgain_ff, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_VGAIN) vgain_ff <= merge(vgain_ff, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_VDIV && wb_sel_i[0]) vdiv_ff <= wb_dat_i[7:0];
        else if (wb_adr_i == ADR_ACCDEC) accdec_ff <= merge(accdec_ff, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_PROF_VEL) prof_ff <= merge(prof_ff, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_CUR_LIM) cur_lim_ff <= merge(cur_lim_ff, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_CI_THERM) {therm_ff, ci_ff} <= merge({therm_ff, ci_ff}, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_ERR_DELAY) err_delay_ff <= merge(err_delay_ff, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_MAX_DEV) max_dev_ff <= merge(max_dev_ff, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == ADR_ERR_CFG) err_cfg_ff <= merge(err_cfg_ff, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Control loops run once per base period; the velocity loop every vdiv periods.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt_ff <= 32'h0;
      vcnt_ff <= 8'h0;
      perr_prev_ff <= 32'sh0;
      vset_ff <= 32'sh0;
      integ_ff <= 32'sh0;
      cmd_ff <= 32'sh0;
      lim_ff <= 32'sh0;
      i2t_ff <= 32'h0;
      limiting_ff <= 1'b0;
    end
    else
    begin
      tick_cnt_ff <= tick ? 32'h0 : tick_cnt_ff + 32'h1;
      if (tick)
      begin
        vcnt_ff <= sample ? 8'h0 : vcnt_ff + 8'h1;
        lim_ff <= lim_ff + lstep;
        i2t_ff <= i2t_n;
        if (i2t_n >= {therm_ff, 16'h0}) limiting_ff <= 1'b1;
        else if (i2t_n == 32'h0) limiting_ff <= 1'b0;
        perr_prev_ff <= perr;
        if (state_ff == ST_ENABLED)
        begin
          vset_ff <= ramp_v;
          if (sample)
          begin
            cmd_ff <= cmd_c;
            // The integrator freezes while a limit switch blocks, so it does not wind up.
            if (blk_ff == 2'b00) integ_ff <= integ_ff + ki_prod[39:8];
          end
        end
        else
        begin
          vset_ff <= 32'sh0;
          integ_ff <= 32'sh0;
          cmd_ff <= 32'sh0;
        end
      end
    end
  end

  // Target corridor dwell and status transmission.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dwell_ff <= 32'h0;
      reached_ff <= 1'b0;
      pdo_ff <= 1'b0;
    end
    else
    begin
      if (new_tgt_ff || !in_win)
      begin
        dwell_ff <= 32'h0;
        reached_ff <= 1'b0;
      end
      else if (tick)
      begin
        if (dwell_ff >= win_time_ff) reached_ff <= 1'b1;
        else dwell_ff <= dwell_ff + 32'h1;
      end
      pdo_ff <= (err_cfg_ff[CFG_PDO_LO +: 8] == PDO_ASYNC_TYPE) &&
                ((new_tgt_ff || !in_win) ? reached_ff : (tick && dwell_ff >= win_time_ff && !reached_ff));
    end
  end

  for (genvar k = 0; k < 3; k++)
  begin : g_err
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        err_cnt_ff[k] <= 32'h0;
        err_ff[k] <= 1'b0;
      end
      else if (!err_cond[k])
      begin
        err_cnt_ff[k] <= 32'h0;
        err_ff[k] <= 1'b0;
      end
      else
      begin
        if (err_cnt_ff[k] < err_delay_ff) err_cnt_ff[k] <= err_cnt_ff[k] + 32'h1;
        err_ff[k] <= err_cnt_ff[k] >= err_delay_ff;
      end
    end
    err_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(err_ff[k]) |-> $past(err_cond[k], 1) && $past(err_cnt_ff[k]) >= $past(err_delay_ff))
      else $error("fault raised before its delay");
  end

  // Limit switches latch on the chosen edge and release on the opposite one.
  for (genvar k = 0; k < 2; k++)
  begin : g_lim
    logic sw, pol;
    assign sw = k == 0 ? limit_pos_i : limit_neg_i;
    assign pol = ctrl_ff[CTRL_POL_POS + k];
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        lim_prev_ff[k] <= 1'b0;
        blk_ff[k] <= 1'b0;
      end
      else
      begin
        lim_prev_ff[k] <= sw;
        if (pol ? (sw & ~lim_prev_ff[k]) : (~sw & lim_prev_ff[k])) blk_ff[k] <= 1'b1;
        else if (pol ? (~sw & lim_prev_ff[k]) : (sw & ~lim_prev_ff[k])) blk_ff[k] <= 1'b0;
      end
    end
  end

  // Homing zeroes the position by capturing the encoder count as offset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_prev_ff <= 1'b0;
      offset_ff <= 32'sh0;
      zero_ff <= 1'b0;
      home_done_ff <= 1'b0;
    end
    else
    begin
      src_prev_ff <= home_src;
      zero_ff <= ctrl_ff[CTRL_HOME_EN] && home_hit;
      if (ctrl_ff[CTRL_HOME_EN] && home_hit) offset_ff <= $signed(enc_pos_i);
      if (ctrl_ff[CTRL_HOME_EN] && home_hit) home_done_ff <= 1'b1;
      else if (wr && wb_adr_i == ADR_STATUS && wb_sel_i[0] && wb_dat_i[STS_HOME]) home_done_ff <= 1'b0;
    end
  end

  // Drive profile state; a new fault wins over a simultaneous clear.
  always_ff @(posedge clk_i)
  begin
    if (rst_i) state_ff <= ST_DISABLED;
    else
    begin
      case (state_ff)
        ST_DISABLED: if (ctrl_ff[CTRL_ENABLE]) state_ff <= ST_ENABLED;
        ST_ENABLED:
          if (|(err_ff & err_cfg_ff[CFG_SEL_LO +: 3])) state_ff <= ST_FAULT;
          else if (!ctrl_ff[CTRL_ENABLE]) state_ff <= ST_DISABLED;
        default:
          if (wr && wb_adr_i == ADR_STATUS && wb_sel_i[0] && wb_dat_i[STS_FAULT] &&
              !(|(err_ff & err_cfg_ff[CFG_SEL_LO +: 3]))) state_ff <= ST_DISABLED;
      endcase
    end
  end

  // Emergency requests and fault pin drive.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      emcy_ff <= 1'b0;
      emcy_code_ff <= 3'h0;
      pin_o_ff <= 1'b1;
      pin_oe_ff <= 1'b1;
      fault_ff <= 1'b0;
    end
    else
    begin
      emcy_ff <= |(err_cond & {err_cnt_ff[2] >= err_delay_ff, err_cnt_ff[1] >= err_delay_ff,
                 err_cnt_ff[0] >= err_delay_ff} & ~err_ff & err_cfg_ff[CFG_EMCY_LO +: 3]);
      emcy_code_ff <= err_cond & {err_cnt_ff[2] >= err_delay_ff, err_cnt_ff[1] >= err_delay_ff,
                      err_cnt_ff[0] >= err_delay_ff} & ~err_ff & err_cfg_ff[CFG_EMCY_LO +: 3];
      pin_oe_ff <= fn != FN_REF_IN;
      fault_ff <= state_ff == ST_FAULT;
      case (fn)
        FN_ERROR: pin_o_ff <= !(|(err_ff & err_cfg_ff[CFG_PIN_LO +: 3]));
        FN_TARGET: pin_o_ff <= !reached_ff;
        FN_GENERAL: pin_o_ff <= ctrl_ff[CTRL_GEN_OUT];
        default: pin_o_ff <= 1'b0;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign fault_pin_o = pin_o_ff;
  assign fault_pin_oe_o = pin_oe_ff;
  assign current_cmd_o = cmd_ff;
  assign pos_zero_o = zero_ff;
  assign emcy_req_o = emcy_ff;
  assign emcy_code_o = emcy_code_ff;
  assign pdo_req_o = pdo_ff;
  assign fault_state_o = fault_ff;
  assign target_reached_o = reached_ff;
  assign current_limiting_o = limiting_ff;

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) ack_ff |=> !ack_ff)
    else $error("ack held for two cycles");
  reached_dwell_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(reached_ff) |-> $past(dwell_ff) >= $past(win_time_ff) && $past(in_win))
    else $error("target reached without dwell");
  reached_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!in_win || new_tgt_ff) |=> !reached_ff && dwell_ff == 32'h0)
    else $error("reached not cleared");
  pdo_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (reached_ff != $past(reached_ff)) && $past(err_cfg_ff[31:24]) == 8'hff |-> pdo_ff)
    else $error("status change not sent");
  fault_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_ENABLED && |(err_ff & err_cfg_ff[18:16]) |=> state_ff == ST_FAULT)
    else $error("selected error did not fault");
  pin_target_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fn == FN_TARGET |=> fault_pin_o == !$past(reached_ff) && fault_pin_oe_o)
    else $error("target pin level wrong");
  pin_general_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fn == FN_GENERAL |=> fault_pin_o == $past(ctrl_ff[3]))
    else $error("general pin level wrong");
  ref_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fn == FN_REF_IN |=> !fault_pin_oe_o)
    else $error("reference pin driven");
  limit_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    blk_ff[0] && sample |=> cmd_ff <= 32'sh0)
    else $error("blocked direction still driven");
  cur_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sample |=> cmd_ff <= $past(lim_ff) && cmd_ff >= -$past(lim_ff))
    else $error("current command above limit");
endmodule : drive_loop_and_fault_signalling

//--- fieldbus_master_model.sv
// Fieldbus master model issuing classic Wishbone single cycles.
// Assumes a slave on clk_i that answers with a registered ack.
`timescale 1ns/1ns
module fieldbus_master_model (
  // Bus answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  // Bus request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] wdat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} = '0;

  // The request stands until ack is sampled or 16 cycles pass; a slave slower than that fails the access.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} <= {2'b11, w, a, 4'hf, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 16);
    ok = (ack_i === 1'b1);
    q = rdat_i;
    {cyc_o, stb_o} <= 2'b00;
  endtask : xfer
endmodule : fieldbus_master_model

//--- testbench.sv
// Self-checking bench for the drive loop and fault signalling block.
// Assumes the fault pin line has a pull-up when nobody drives it.
`timescale 1ns/1ns
module testbench;
  import drive_loop_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] enc_pos = 32'h0;
  logic [1:0] flt = 2'h0;
  logic [1:0] lim = 2'h0;
  logic [31:0] rq;
  logic ack, pin_o, pin_oe, emcy, pdo, fstate, reached;
  logic cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [2:0] code;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  wire pin_lvl = pin_oe ? pin_o : 1'b1;
  wire [3:0] ev = {fstate, emcy, pdo, reached};

  always #2 clk_i = ~clk_i;

  fieldbus_master_model bus (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .wdat_o(wdat));

  drive_loop_and_fault_signalling #(.BASE_CYC(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .enc_pos_i(enc_pos), .vel_act_i(32'h0), .cur_act_i(16'h0),
    .overcurrent_i(flt[0]), .overvoltage_i(flt[1]), .limit_pos_i(lim[0]), .limit_neg_i(lim[1]),
    .home_sw_i(1'b0), .fault_pin_i(pin_lvl), .fault_pin_o(pin_o), .fault_pin_oe_o(pin_oe),
    .current_cmd_o(), .pos_zero_o(), .emcy_req_o(emcy), .emcy_code_o(code), .pdo_req_o(pdo),
    .fault_state_o(fstate), .target_reached_o(reached), .current_limiting_o());

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    bus.xfer(w, a, d, rq, ok);
    chk("ack", {31'h0, ok}, 32'h1);
    if (ok !== 1'b1)
      give_verdict();
  endtask : acc

  // A pulse lasts one cycle, so every edge is visited while waiting.
  task automatic wait_ev(input int b, input int lim, input bit must);
    n = 0;
    while (ev[b] !== 1'b1 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    if (must && n == lim)
    begin
      chk("wait", 32'h0, 32'h1);
      give_verdict();
    end
  endtask : wait_ev

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(1'b0, ADR_WIN, 32'h0);
    chk("win", rq, WIN_RST);
    acc(1'b0, ADR_ERR_CFG, 32'h0);
    chk("errcfg", rq, ERR_CFG_RST);
    acc(1'b0, 8'h7c, 32'h0);
    chk("unmapped", rq, 32'h0);
    acc(1'b1, ADR_CTRL, 32'h3);
    enc_pos <= 32'h100;
    acc(1'b1, ADR_WIN_TIME, 32'h4);
    acc(1'b1, ADR_TARGET, 32'h100);
    wait_ev(0, 100, 1'b1);
    chk("dwell", {31'h0, n >= 24 && n <= 56}, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("pin_reached", {31'h0, pin_lvl}, 32'h0);
    acc(1'b1, ADR_TARGET, 32'h180);
    wait_ev(1, 16, 1'b1);
    chk("reached", {31'h0, reached}, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("pin_moving", {31'h0, pin_lvl}, 32'h1);
    for (int v = 0; v < 2; v++)
    begin
      acc(1'b1, ADR_CTRL, 32'h5 | (v << 3));
      repeat (2) @(posedge clk_i);
      chk("pin_gen", {31'h0, pin_lvl}, v);
    end
    acc(1'b1, ADR_CTRL, 32'h7);
    repeat (2) @(posedge clk_i);
    chk("pin_ref_oe", {31'h0, pin_oe}, 32'h0);
    acc(1'b1, ADR_CTRL, 32'h31);
    lim <= 2'h3;
    repeat (8) @(posedge clk_i);
    acc(1'b0, ADR_STATUS, 32'h0);
    chk("blocked", rq & 32'h180, 32'h180);
    lim <= 2'h0;
    repeat (2) @(posedge clk_i);
    acc(1'b0, ADR_STATUS, 32'h0);
    chk("released", rq & 32'h180, 32'h0);
    acc(1'b1, ADR_CTRL, 32'h1);
    acc(1'b1, ADR_ERR_DELAY, 32'h10);
    acc(1'b1, ADR_ERR_CFG, 32'hff07_0707);
    for (int k = 0; k < 2; k++)
    begin
      flt <= 2'(1 << k);
      repeat (8) @(posedge clk_i);
      flt <= 2'h0;
      wait_ev(2, 40, 1'b0);
      chk("short_pulse", n, 40);
      flt <= 2'(1 << k);
      wait_ev(2, 60, 1'b1);
      chk("delay", {31'h0, n >= 15}, 32'h1);
      chk("code", {29'h0, code}, 32'h1 << k);
      repeat (2) @(posedge clk_i);
      chk("pin_err", {31'h0, pin_lvl}, 32'h0);
      chk("fault", {31'h0, fstate}, 32'h1);
      flt <= 2'h0;
      acc(1'b1, ADR_STATUS, 32'h20);
      repeat (2) @(posedge clk_i);
      chk("fault_clr", {31'h0, fstate}, 32'h0);
    end
    give_verdict();
  end
endmodule : testbench
